// ===== rtl/cfd_params.svh
`ifndef CFD_PARAMS_SVH
`define CFD_PARAMS_SVH

`define CFD_CLK_HZ 200000000
`define CFD_MAX_BPS 1000000
`define CFD_MIN_BIT_CYC (`CFD_CLK_HZ / `CFD_MAX_BPS)
`define CFD_STUFF_LIMIT 3'd5
`define CFD_CRC_POLY 15'h4599
`define CFD_CRC_BITS 8'd15
`define CFD_STD_ARB_LAST 8'd13
`define CFD_EXT_ARB_LAST 8'd32
`define CFD_STD_DATA_POS 8'd19
`define CFD_EXT_DATA_POS 8'd39
`define CFD_STD_ID_LAST 8'd11
`define CFD_STD_RTR_POS 8'd12
`define CFD_IDE_POS 8'd13
`define CFD_EXT_ID_LAST 8'd31
`define CFD_EXT_RTR_POS 8'd32
`define CFD_MAX_BYTES 4'd8
`define CFD_EOF_LAST 8'd6
`define CFD_IFS_LAST 8'd2
`define CFD_ERR_FLAG_LAST 8'd5
`define CFD_ERR_DELIM_LAST 8'd7
`define CFD_MSG_WORDS 3'd7
`define CFD_TX_BUFS 8
`define CFD_LAST_BUF 5'd31
`define CFD_FIFO_PTR_RST 5'd8
`define CFD_TX_FRAME_MSB 7'd102

`endif

// ===== rtl/cfd_pkg.sv
package cfd_pkg;

  typedef enum logic [3:0] {
    CFD_IDLE      = 4'h0,
    CFD_BODY      = 4'h1,
    CFD_CRC_DELIM = 4'h2,
    CFD_ACK_SLOT  = 4'h3,
    CFD_ACK_DELIM = 4'h4,
    CFD_EOF       = 4'h5,
    CFD_IFS       = 4'h6,
    CFD_ERR_FLAG  = 4'h7,
    CFD_ERR_DELIM = 4'h8
  } cfd_state_e;

  typedef struct packed {
    logic        en;
    logic        ide;
    logic        use_fifo;
    logic [1:0]  mask_sel;
    logic [4:0]  buf_idx;
    logic [28:0] id;
  } cfd_filter_s;

  typedef struct packed {
    logic        match_ide;
    logic [28:0] id_mask;
  } cfd_mask_s;

  typedef struct packed {
    logic        en;
    logic        auto_rtr;
    logic        ide;
    logic [28:0] id;
  } cfd_txcfg_s;

  typedef struct packed {
    logic [4:0]  buf_idx;
    logic [15:0] data;
  } cfd_rxword_s;

endpackage

// ===== rtl/cfd_controller.sv
// How it works
// - only buffers 0-7 may transmit
// - each received word raises receive dma request
// - transmit dma request fetches each message word
// - store message only when a filter accepts
// - sixteen filters, three selectable mask sets
// - receive fifo arrangement up to 32 buffers
// - programmable bit rate, at most 1 Mbps
// - start bit first, end field last
// - payload carries zero to eight bytes
// - standard arbitration: 11-bit id plus rtr
// - data frame sends rtr dominant
// - six-bit control field, ide dominant standard
// - reserved control bit sent dominant
// - four-bit length code gives payload bytes
// - fifteen-bit crc then one delimiter bit
// - sender recessive ack, good receivers dominant
// - acknowledge regardless of filter result
// - seven-bit end field, three-bit intermission
// - handle both 11-bit and 29-bit identifiers
// - answer matching remote frames automatically
// - detected bus errors send an error frame
// - remote frame: rtr recessive, no payload
// - extended arbitration: srr and ide recessive
`timescale 1ns/1ps
`include "cfd_params.svh"

module cfd_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("cfd_fifo depth must be a power of two");
  end

  assign in_ready_out = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != '0);
  assign out_data_out = mem_r[rd_ptr_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule

module cfd_controller #(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_MASKS = 3,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic can_rx_in,
  output logic can_tx_out,
  input wire logic [15:0] bit_cycles_in,
  input cfd_pkg::cfd_filter_s filter_cfg_in [NUM_FILTERS],
  input cfd_pkg::cfd_mask_s mask_cfg_in [NUM_MASKS],
  input wire logic [4:0] fifo_start_in,
  input cfd_pkg::cfd_txcfg_s tx_cfg_in [`CFD_TX_BUFS],
  input wire logic [`CFD_TX_BUFS-1:0] tx_request_in,
  output logic rx_dma_req_out,
  input wire logic rx_dma_rd_in,
  output logic [15:0] rx_data_word_reg_out,
  output logic [4:0] rx_buf_out,
  output logic tx_dma_req_out,
  input wire logic tx_dma_wr_in,
  input wire logic [15:0] tx_dma_wdata_in,
  output logic [2:0] tx_buf_out,
  output logic [2:0] tx_word_idx_out,
  output logic tx_done_out,
  output logic rx_overflow_out,
  output logic bus_error_out
);
  import cfd_pkg::*;

  if (NUM_FILTERS < 1 || NUM_FILTERS > 16 || NUM_MASKS < 1 || NUM_MASKS > 3
      || FIFO_DEPTH < 8) begin : g_chk
    $error("cfd_controller parameters out of range");
  end

  // bit timing
  logic [15:0] bit_cyc;
  logic [15:0] cnt_r;
  logic rx_prev_r;
  logic boundary;
  logic sample;
  logic b;
  logic tx_active_r;
  assign bit_cyc = (bit_cycles_in < 16'(`CFD_MIN_BIT_CYC)) ? 16'(`CFD_MIN_BIT_CYC)
                   : bit_cycles_in;
  assign boundary = (cnt_r == 16'h0);
  assign sample = (cnt_r == {1'b0, bit_cyc[15:1]});
  assign b = can_rx_in;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_r <= 16'h0;
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= can_rx_in;
      // receivers resync on falling edges; a sender keeps its own timing
      if (rx_prev_r && !can_rx_in && !tx_active_r) cnt_r <= 16'h1;
      else if (cnt_r >= bit_cyc - 16'h1) cnt_r <= 16'h0;
      else cnt_r <= cnt_r + 16'h1;
    end
  end

  // protocol state
  cfd_state_e st_r;
  logic [7:0] pos_r;
  logic [2:0] same_r;
  logic last_r;
  logic [14:0] crc_r;
  logic [14:0] crc_nxt;
  logic crc_ok_r;
  logic [28:0] id_r;
  logic ide_r;
  logic rtr_r;
  logic [3:0] dlc_r;
  logic [63:0] data_r;
  logic drive_r;
  logic drive_nxt;
  logic [3:0] nbytes;
  logic [7:0] hdr_end;
  logic [7:0] data_end;
  logic [7:0] crc_end;
  logic [7:0] pos_nxt;
  logic [2:0] same_nxt;
  logic stuff_bit;
  logic arb_region;
  logic err_now;
  logic lose_arb;
  logic frame_done;
  logic tx_start;
  logic tx_ready_r;
  logic tx_ide_r;
  logic [102:0] tx_frame_r;
  logic [28:0] rx_id;

  assign nbytes = rtr_r ? 4'h0 : ((dlc_r > `CFD_MAX_BYTES) ? `CFD_MAX_BYTES : dlc_r);
  assign hdr_end = ide_r ? `CFD_EXT_DATA_POS : `CFD_STD_DATA_POS;
  assign data_end = hdr_end + {1'b0, nbytes, 3'b000};
  assign crc_end = data_end + `CFD_CRC_BITS;
  assign crc_nxt = {crc_r[13:0], 1'b0} ^ ((b ^ crc_r[14]) ? `CFD_CRC_POLY : 15'h0);
  assign pos_nxt = pos_r + 8'h1;
  assign same_nxt = (b == last_r) ? same_r + 3'h1 : 3'h1;
  assign stuff_bit = (same_r == `CFD_STUFF_LIMIT);
  assign arb_region = (pos_r <= `CFD_STD_ARB_LAST)
                      || (tx_ide_r && pos_r <= `CFD_EXT_ARB_LAST);
  assign rx_id = ide_r ? id_r : {id_r[10:0], 18'h0};
  assign tx_start = boundary && st_r == CFD_IDLE && tx_ready_r && !tx_active_r;
  assign frame_done = sample && st_r == CFD_EOF && pos_r == `CFD_EOF_LAST && !err_now;

  // value put on the bus at the next bit start
  always_comb begin
    drive_nxt = 1'b1;
    unique case (st_r)
      CFD_IDLE: drive_nxt = !tx_start;
      CFD_BODY: begin
        if (tx_active_r) begin
          if (stuff_bit) drive_nxt = !last_r;
          else if (pos_r < data_end) drive_nxt = tx_frame_r[`CFD_TX_FRAME_MSB - pos_r[6:0]];
          else drive_nxt = crc_r[14];
        end
      end
      CFD_ACK_SLOT: drive_nxt = tx_active_r | !crc_ok_r;
      CFD_ERR_FLAG: drive_nxt = 1'b0;
      CFD_CRC_DELIM, CFD_ACK_DELIM, CFD_EOF, CFD_IFS, CFD_ERR_DELIM: drive_nxt = 1'b1;
      default: drive_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      drive_r <= 1'b1;
    end else if (boundary) begin
      drive_r <= drive_nxt;
    end
  end
  assign can_tx_out = drive_r;

  // error detection at the sample point
  always_comb begin
    err_now = 1'b0;
    lose_arb = 1'b0;
    if (sample) begin
      unique case (st_r)
        CFD_BODY: begin
          if (stuff_bit) err_now = (b == last_r);
          else if (tx_active_r && b != drive_r) begin
            if (arb_region && drive_r) lose_arb = 1'b1;
            else err_now = 1'b1;
          end
        end
        CFD_CRC_DELIM, CFD_EOF: err_now = !b;
        CFD_ACK_SLOT: err_now = tx_active_r && b;
        CFD_ACK_DELIM: err_now = !b || (!tx_active_r && !crc_ok_r);
        // dominant early in the gap is answered with an overload frame of the same form
        CFD_IFS: err_now = !b && pos_r < `CFD_IFS_LAST;
        CFD_IDLE, CFD_ERR_FLAG, CFD_ERR_DELIM: err_now = 1'b0;
        default: err_now = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_r <= CFD_IDLE;
      pos_r <= 8'h0;
      same_r <= 3'h0;
      last_r <= 1'b1;
      crc_r <= 15'h0;
      crc_ok_r <= 1'b0;
      id_r <= 29'h0;
      ide_r <= 1'b0;
      rtr_r <= 1'b0;
      dlc_r <= 4'h0;
      data_r <= 64'h0;
    end else if (sample) begin
      if (err_now) begin
        st_r <= CFD_ERR_FLAG;
        pos_r <= 8'h0;
      end else begin
        unique case (st_r)
          CFD_IDLE, CFD_IFS: begin
            if (!b) begin
              st_r <= CFD_BODY;
              pos_r <= 8'h1;
              same_r <= 3'h1;
              last_r <= 1'b0;
              crc_r <= 15'h0;
              ide_r <= 1'b0;
              rtr_r <= 1'b0;
            end else if (st_r == CFD_IFS) begin
              pos_r <= pos_nxt;
              if (pos_r == `CFD_IFS_LAST) st_r <= CFD_IDLE;
            end
          end
          CFD_BODY: begin
            if (stuff_bit) begin
              same_r <= 3'h1;
              last_r <= b;
              if (pos_r == crc_end) begin
                st_r <= CFD_CRC_DELIM;
                pos_r <= 8'h0;
              end
            end else begin
              same_r <= same_nxt;
              last_r <= b;
              crc_r <= crc_nxt;
              pos_r <= pos_nxt;
              if (pos_r <= `CFD_STD_ID_LAST) id_r <= {id_r[27:0], b};
              if (pos_r == `CFD_STD_RTR_POS) rtr_r <= b;
              if (pos_r == `CFD_IDE_POS) ide_r <= b;
              if (ide_r && pos_r > `CFD_IDE_POS && pos_r <= `CFD_EXT_ID_LAST) begin
                id_r <= {id_r[27:0], b};
              end
              if (ide_r && pos_r == `CFD_EXT_RTR_POS) rtr_r <= b;
              if (pos_r >= hdr_end - 8'h4 && pos_r < hdr_end) dlc_r <= {dlc_r[2:0], b};
              if (pos_r >= hdr_end && pos_r < data_end) data_r <= {data_r[62:0], b};
              if (pos_nxt == crc_end) begin
                crc_ok_r <= (crc_nxt == 15'h0);
                if (same_nxt != `CFD_STUFF_LIMIT) begin
                  st_r <= CFD_CRC_DELIM;
                  pos_r <= 8'h0;
                end
              end
            end
          end
          CFD_CRC_DELIM: st_r <= CFD_ACK_SLOT;
          CFD_ACK_SLOT: st_r <= CFD_ACK_DELIM;
          CFD_ACK_DELIM: st_r <= CFD_EOF;
          CFD_EOF: begin
            pos_r <= pos_nxt;
            if (pos_r == `CFD_EOF_LAST) begin
              st_r <= CFD_IFS;
              pos_r <= 8'h0;
            end
          end
          CFD_ERR_FLAG: begin
            pos_r <= pos_nxt;
            if (pos_r == `CFD_ERR_FLAG_LAST) begin
              st_r <= CFD_ERR_DELIM;
              pos_r <= 8'h0;
            end
          end
          CFD_ERR_DELIM: begin
            // delimiter restarts until eight recessive bits in a row
            pos_r <= b ? pos_nxt : 8'h0;
            if (b && pos_r == `CFD_ERR_DELIM_LAST) begin
              st_r <= CFD_IFS;
              pos_r <= 8'h0;
            end
          end
          default: st_r <= CFD_IDLE;
        endcase
      end
    end
  end

  // acceptance filtering, lowest matching filter wins
  logic hit;
  logic [3:0] hit_idx;
  logic [4:0] hit_buf;
  logic hit_fifo;
  logic [28:0] cmp_mask;
  logic cmp_ide;
  always_comb begin
    hit = 1'b0;
    hit_idx = 4'h0;
    hit_buf = 5'h0;
    hit_fifo = 1'b0;
    cmp_mask = '1;
    cmp_ide = 1'b1;
    for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
      // an unimplemented mask set falls back to an exact compare
      if (int'(filter_cfg_in[i].mask_sel) < NUM_MASKS) begin
        cmp_mask = mask_cfg_in[filter_cfg_in[i].mask_sel].id_mask;
        cmp_ide = mask_cfg_in[filter_cfg_in[i].mask_sel].match_ide;
      end else begin
        cmp_mask = '1;
        cmp_ide = 1'b1;
      end
      if (filter_cfg_in[i].en && ((rx_id ^ filter_cfg_in[i].id) & cmp_mask) == 29'h0
          && (!cmp_ide || filter_cfg_in[i].ide == ide_r)) begin
        hit = 1'b1;
        hit_idx = 4'(i);
        hit_buf = filter_cfg_in[i].buf_idx;
        hit_fifo = filter_cfg_in[i].use_fifo;
      end
    end
  end

  // fifo-style buffer rotation from the start buffer up to buffer 31
  logic sto_busy_r;
  logic [4:0] fifo_ptr_r;
  logic [4:0] fifo_dest;
  logic [4:0] dest_buf;
  logic dest_ok;
  logic accept;
  assign fifo_dest = (fifo_ptr_r < fifo_start_in) ? fifo_start_in : fifo_ptr_r;
  assign dest_buf = hit_fifo ? fifo_dest : hit_buf;
  // a buffer set up for sending never takes received data
  assign dest_ok = !(dest_buf < 5'(`CFD_TX_BUFS) && tx_cfg_in[dest_buf[2:0]].en);
  assign accept = frame_done && !tx_active_r && !rtr_r && hit && dest_ok;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fifo_ptr_r <= `CFD_FIFO_PTR_RST;
    end else if (accept && hit_fifo && !sto_busy_r) begin
      fifo_ptr_r <= (fifo_dest == `CFD_LAST_BUF) ? fifo_start_in : fifo_dest + 5'h1;
    end
  end

  // message store into the receive fifo
  logic [2:0] sto_idx_r;
  logic [4:0] sto_buf_r;
  logic [111:0] sto_msg_r;
  logic [63:0] data_al;
  logic sto_ready;
  logic rx_overflow_r;
  assign data_al = data_r << {7'h40 - {nbytes, 3'b000}};

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sto_busy_r <= 1'b0;
      sto_idx_r <= 3'h0;
      sto_buf_r <= 5'h0;
      sto_msg_r <= 112'h0;
      rx_overflow_r <= 1'b0;
    end else begin
      // overflow drops the newer frame; the one already queued stays whole
      rx_overflow_r <= accept && sto_busy_r;
      if (accept && !sto_busy_r) begin
        sto_busy_r <= 1'b1;
        sto_idx_r <= 3'h0;
        sto_buf_r <= dest_buf;
        sto_msg_r <= {ide_r, rtr_r, 1'b0, rx_id[28:16], rx_id[15:0],
                      4'h0, hit_idx, 4'h0, dlc_r, data_al};
      end else if (sto_busy_r && sto_ready) begin
        sto_msg_r <= {sto_msg_r[95:0], 16'h0};
        sto_idx_r <= sto_idx_r + 3'h1;
        if (sto_idx_r == `CFD_MSG_WORDS - 3'h1) sto_busy_r <= 1'b0;
      end
    end
  end

  cfd_rxword_s fifo_out;
  logic fifo_valid;
  logic fifo_pop;
  logic rx_req_r;
  logic [15:0] rx_word_r;
  logic [4:0] rx_buf_r;
  assign fifo_pop = fifo_valid && (!rx_req_r || rx_dma_rd_in);

  cfd_fifo #(
    .WIDTH($bits(cfd_rxword_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(sto_busy_r),
    .in_ready_out(sto_ready),
    .in_data_in({sto_buf_r, sto_msg_r[111:96]}),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out)
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rx_req_r <= 1'b0;
      rx_word_r <= 16'h0;
      rx_buf_r <= 5'h0;
    end else if (fifo_pop) begin
      rx_req_r <= 1'b1;
      rx_word_r <= fifo_out.data;
      rx_buf_r <= fifo_out.buf_idx;
    end else if (rx_dma_rd_in) begin
      rx_req_r <= 1'b0;
    end
  end
  assign rx_dma_req_out = rx_req_r;
  assign rx_data_word_reg_out = rx_word_r;
  assign rx_buf_out = rx_buf_r;

  // transmit pending, auto remote answer, fetch
  logic [`CFD_TX_BUFS-1:0] pend_r;
  logic [`CFD_TX_BUFS-1:0] pend_set;
  logic [2:0] sel;
  logic fetch_busy_r;
  logic build_r;
  logic tx_req_r;
  logic [2:0] tx_buf_r;
  logic [2:0] fw_idx_r;
  logic [15:0] tx_data_word_reg_r;
  logic [111:0] tx_msg_r;
  logic tx_done_r;
  logic bus_err_r;
  logic [28:0] q_id;
  logic q_ide;
  logic q_rtr;
  logic [3:0] q_dlc;

  always_comb begin
    pend_set = '0;
    sel = 3'h0;
    for (int i = 0; i < `CFD_TX_BUFS; i++) begin
      if (tx_cfg_in[i].en) begin
        pend_set[i] = tx_request_in[i];
        if (frame_done && !tx_active_r && rtr_r && tx_cfg_in[i].auto_rtr
            && tx_cfg_in[i].ide == ide_r
            && (ide_r ? tx_cfg_in[i].id == rx_id
                      : tx_cfg_in[i].id[28:18] == rx_id[28:18])) begin
          pend_set[i] = 1'b1;
        end
      end
    end
    for (int i = `CFD_TX_BUFS - 1; i >= 0; i--) begin
      if (pend_r[i]) sel = 3'(i);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pend_r <= '0;
    end else begin
      // a new request in the finishing cycle keeps the buffer pending
      pend_r <= (pend_r & ~((frame_done && tx_active_r) ? (8'h1 << tx_buf_r) : 8'h0))
                | pend_set;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      fetch_busy_r <= 1'b0;
      build_r <= 1'b0;
      tx_req_r <= 1'b0;
      tx_buf_r <= 3'h0;
      fw_idx_r <= 3'h0;
      tx_data_word_reg_r <= 16'h0;
      tx_msg_r <= 112'h0;
    end else begin
      build_r <= 1'b0;
      if (!fetch_busy_r && !build_r && !tx_ready_r && !tx_active_r && pend_r != '0) begin
        fetch_busy_r <= 1'b1;
        tx_buf_r <= sel;
        fw_idx_r <= 3'h0;
        tx_req_r <= 1'b1;
      end else if (tx_req_r && tx_dma_wr_in) begin
        tx_req_r <= 1'b0;
        tx_data_word_reg_r <= tx_dma_wdata_in;
        tx_msg_r <= {tx_msg_r[95:0], tx_dma_wdata_in};
        fw_idx_r <= fw_idx_r + 3'h1;
        if (fw_idx_r == `CFD_MSG_WORDS - 3'h1) begin
          fetch_busy_r <= 1'b0;
          build_r <= 1'b1;
        end
      end else if (fetch_busy_r && !tx_req_r) begin
        tx_req_r <= 1'b1;
      end
    end
  end

  assign q_ide = tx_msg_r[111];
  assign q_rtr = tx_msg_r[110];
  assign q_id = tx_msg_r[108:80];
  assign q_dlc = q_rtr ? 4'h0 : tx_msg_r[67:64];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      tx_ready_r <= 1'b0;
      tx_ide_r <= 1'b0;
      tx_frame_r <= '1;
      tx_active_r <= 1'b0;
      tx_done_r <= 1'b0;
      bus_err_r <= 1'b0;
    end else begin
      tx_done_r <= frame_done && tx_active_r;
      bus_err_r <= err_now;
      if (build_r) begin
        tx_ready_r <= 1'b1;
        tx_ide_r <= q_ide;
        if (q_ide) begin
          tx_frame_r <= {1'b0, q_id[28:18], 1'b1, 1'b1, q_id[17:0], q_rtr, 2'b00,
                         q_dlc, tx_msg_r[63:0]};
        end else begin
          tx_frame_r <= {1'b0, q_id[28:18], q_rtr, 1'b0, 1'b0, q_dlc,
                         tx_msg_r[63:0], 20'h0};
        end
      end else if (frame_done && tx_active_r) begin
        tx_ready_r <= 1'b0;
      end
      // lost arbitration or error keeps the frame ready for a retry
      if (tx_start) tx_active_r <= 1'b1;
      else if (err_now || lose_arb || frame_done) tx_active_r <= 1'b0;
    end
  end

  assign tx_dma_req_out = tx_req_r;
  assign tx_buf_out = tx_buf_r;
  assign tx_word_idx_out = fw_idx_r;
  assign tx_done_out = tx_done_r;
  assign rx_overflow_out = rx_overflow_r;
  assign bus_error_out = bus_err_r;
endmodule

// ===== tb/cfd_controller_monitor.sv
`timescale 1ns/1ps
module cfd_controller_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic can_tx_out,
  input wire logic rx_dma_req_out,
  input wire logic rx_dma_rd_in,
  input wire logic [15:0] rx_data_word_reg_out,
  input wire logic [4:0] rx_buf_out,
  input wire logic tx_dma_req_out,
  input wire logic tx_dma_wr_in,
  input wire logic [2:0] tx_buf_out,
  input wire logic [2:0] tx_word_idx_out,
  input wire logic tx_done_out,
  input wire logic bus_error_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // bit width counter saturates, so idle stretches never wrap
  logic prev_r;
  logic [15:0] gap_r;
  always_ff @(posedge clk_sys_in) begin
    prev_r <= can_tx_out;
    if (rst_in) gap_r <= 16'hffff;
    else if (can_tx_out != prev_r) gap_r <= 16'h0001;
    else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
  end
  sequence refetch_s;
    !tx_dma_req_out ##1 tx_dma_req_out;
  endsequence
  sequence flag_s;
    ##[0:201] !can_tx_out;
  endsequence
  reset_idle_a: assert property ($fell(rst_in) |-> can_tx_out && !rx_dma_req_out
    && !tx_dma_req_out) else $error("outputs not idle after reset");
  tx_drop_a: assert property (tx_dma_req_out && tx_dma_wr_in |=> !tx_dma_req_out)
    else $error("tx request held after write");
  tx_hold_a: assert property (tx_dma_req_out && !tx_dma_wr_in |=> tx_dma_req_out
    && $stable(tx_word_idx_out) && $stable(tx_buf_out)) else $error("tx request moved");
  idx_step_a: assert property (tx_dma_req_out && tx_dma_wr_in && tx_word_idx_out != 3'h6
    |=> refetch_s ##0 tx_word_idx_out == $past(tx_word_idx_out, 2) + 3'h1)
    else $error("tx word index did not step");
  rx_hold_a: assert property (rx_dma_req_out && !rx_dma_rd_in |=> rx_dma_req_out
    && $stable(rx_data_word_reg_out) && $stable(rx_buf_out)) else $error("rx word moved");
  done_pulse_a: assert property (tx_done_out |=> !tx_done_out)
    else $error("done longer than one cycle");
  bit_time_a: assert property (can_tx_out != prev_r |-> gap_r >= 16'h00c8)
    else $error("bit shorter than 1 us");
  err_flag_a: assert property (bus_error_out |-> flag_s)
    else $error("no dominant flag after error");
endmodule
bind cfd_controller cfd_controller_monitor i_mon (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .can_tx_out(can_tx_out), .rx_dma_req_out(rx_dma_req_out), .rx_dma_rd_in(rx_dma_rd_in),
  .rx_data_word_reg_out(rx_data_word_reg_out), .rx_buf_out(rx_buf_out),
  .tx_dma_req_out(tx_dma_req_out), .tx_dma_wr_in(tx_dma_wr_in), .tx_buf_out(tx_buf_out),
  .tx_word_idx_out(tx_word_idx_out), .tx_done_out(tx_done_out),
  .bus_error_out(bus_error_out));

// ===== tb/cfd_peer.sv
`timescale 1ns/1ps
module cfd_peer #(
  parameter int BIT = 200
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic dut_tx_in,
  output logic bus_out
);
  logic drv_r;
  logic lv_r;
  logic [63:0] sh;
  int cnt, n, run, idl, ack_n;
  bit q[$];
  // wired-and with pull-up: a released line reads recessive
  assign bus_out = drv_r & dut_tx_in;
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt <= 0;
      drv_r <= 1'b1;
      n <= 0;
      idl <= 0;
    end else begin
      cnt <= (cnt == BIT - 1) ? 0 : cnt + 1;
      if (cnt == 0) begin
        if (ack_n != 0 && n == ack_n + 1) drv_r <= 1'b0;
        else drv_r <= q.size() ? q.pop_front() : 1'b1;
      end
      if (cnt == BIT / 2) begin
        idl <= bus_out ? idl + 1 : 0;
        if (n == 0) begin
          n <= !bus_out;
          run <= 1;
          lv_r <= bus_out;
        end else if (bus_out && idl >= 10) n <= 0;
        else if (run == 5 && n <= ack_n) begin
          run <= 1;
          lv_r <= bus_out;
        end else begin
          n <= n + 1;
          if (n < ack_n) sh <= {sh[62:0], bus_out};
          run <= (bus_out == lv_r) ? run + 1 : 1;
          lv_r <= bus_out;
        end
      end
    end
  end
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d,
                      input bit bad);
    bit b[$];
    logic [14:0] c;
    int r;
    bit lv;
    c = 15'h0000;
    r = 0;
    lv = 1'b1;
    b.push_back(1'b0);
    for (int i = 10; i >= 0; i--) b.push_back(id[i]);
    for (int i = 0; i < 7; i++) b.push_back(i > 2 && dlc[6 - i]);
    for (int i = 0; i < 8 * dlc; i++) b.push_back(d[63 - i]);
    foreach (b[i]) c = {c[13:0], 1'b0} ^ ((b[i] ^ c[14]) ? 15'h4599 : 15'h0000);
    c[0] = c[0] ^ bad;
    for (int i = 14; i >= 0; i--) b.push_back(c[i]);
    foreach (b[i]) begin
      r = (b[i] == lv) ? r + 1 : 1;
      lv = b[i];
      q.push_back(lv);
      if (r == 5) begin
        lv = !lv;
        q.push_back(lv);
        r = 1;
      end
    end
  endtask
endmodule

// ===== tb/cfd_controller_bench.sv
`timescale 1ns/1ps
module cfd_controller_bench;
  import cfd_pkg::*;
  logic clk, rst, bus, tx, rxq, rd, txq, wr, done, err, ak, eg, ovf;
  logic [15:0] rdata, wdata;
  logic [4:0] rbuf;
  logic [2:0] tbuf, tidx;
  logic [7:0] treq;
  cfd_filter_s flt [16];
  cfd_mask_s msk [3];
  cfd_txcfg_s tcf [8];
  logic [15:0] rw [7] = '{16'h048c, 16'h0, 16'h0008, 16'h0123, 16'h4567, 16'h89ab, 16'hcdef};
  logic [15:0] tw [7] = '{16'h0a94, 16'h0, 16'h0001, 16'h5a00, 16'h0, 16'h0, 16'h0};
  int num_errors = 0;
  int n_checks = 0;
  cfd_controller i_dut (.clk_sys_in(clk), .rst_in(rst), .can_rx_in(bus), .can_tx_out(tx),
    .bit_cycles_in(16'h00c8), .filter_cfg_in(flt), .mask_cfg_in(msk), .fifo_start_in(5'h08),
    .tx_cfg_in(tcf), .tx_request_in(treq), .rx_dma_req_out(rxq), .rx_dma_rd_in(rd),
    .rx_data_word_reg_out(rdata), .rx_buf_out(rbuf), .tx_dma_req_out(txq),
    .tx_dma_wr_in(wr), .tx_dma_wdata_in(wdata), .tx_buf_out(tbuf), .tx_word_idx_out(tidx),
    .tx_done_out(done), .rx_overflow_out(ovf), .bus_error_out(err));
  cfd_peer i_peer (.clk_sys_in(clk), .rst_in(rst), .dut_tx_in(tx), .bus_out(bus));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task frame(input logic [10:0] id, input logic [3:0] l, input logic [63:0] d, input bit bad);
    ak = 1'b0;
    eg = 1'b0;
    i_peer.send(id, l, d, bad);
    while (i_peer.q.size() > 0) tick(1);
    repeat (4400) begin
      tick(1);
      ak = ak | !tx;
      eg = eg | err;
    end
  endtask
  task get(input logic [15:0] e);
    int k;
    k = 0;
    while (rxq !== 1'b1 && k < 9000) begin
      tick(1);
      k++;
    end
    chk(rdata, e);
    chk({10'h0, rxq, rbuf}, 16'h0029);
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
  endtask
  task put(input logic [15:0] w, input logic [2:0] i);
    int k;
    k = 0;
    while (txq !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    chk({9'h0, txq, tbuf, tidx}, {9'h0, 1'b1, 3'h0, i});
    tick(1);
    wdata = w;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #450000;
    num_errors++;
    wrap_up();
  end
  initial begin
    int k;
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 16'h0;
    treq = 8'h0;
    flt = '{default: '0};
    msk = '{default: '0};
    tcf = '{default: '0};
    flt[0] = '{1'b1, 1'b0, 1'b0, 2'h3, 5'h09, {11'h123, 18'h0}};
    tcf[0] = '{1'b1, 1'b0, 1'b0, {11'h2a5, 18'h0}};
    tick(2);
    rst = 1'b0;
    tick(1);
    chk({13'h0, rxq, txq, tx}, 16'h0001);
    frame(11'h123, 4'h8, 64'h0123456789abcdef, 1'b0);
    chk({15'h0, ak}, 16'h0001);
    foreach (rw[i]) get(rw[i]);
    frame(11'h055, 4'h0, 64'h0, 1'b0);
    chk({14'h0, ak, rxq}, 16'h0002);
    frame(11'h123, 4'h0, 64'h0, 1'b1);
    chk({14'h0, eg, rxq}, 16'h0002);
    i_peer.ack_n = 42;
    treq = 8'h01;
    tick(1);
    treq = 8'h00;
    foreach (tw[i]) put(tw[i], 3'(i));
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      tick(1);
      k++;
    end
    chk({14'h0, ovf, done}, 16'h0001);
    chk(i_peer.sh[40:25], 16'h54a0);
    chk({6'h0, i_peer.sh[24:15]}, 16'h015a);
    wrap_up();
  end
endmodule
